// ---- inc/pll_divider_map.vh ----
// constants for the pll output divider and freeze block
`ifndef PLL_DIVIDER_MAP_VH
`define PLL_DIVIDER_MAP_VH

// divider periods, counted in divider ticks
`define PERIOD_WIDTH         6
`define CORE_PERIOD          6'h04
`define DOUBLE_LEGACY_PERIOD 6'h02
`define QUAL_LOW_TAIL        6'h04

// internal feedback divides the raw vco by 32
`define FEEDBACK_DIV_WIDTH   5

// pci ratio select codes
`define PCI_SEL_BUS          2'h0
`define PCI_SEL_BUS_DIV2     2'h1
`define PCI_SEL_BUS_DIV3     2'h2
`define PCI_SEL_CORE         2'h3

// bus ratio select code for divide by one
`define BUS_SEL_DIV1         2'h0

// output group index, also serial freeze bit position
`define OUT_GROUPS           5
`define GRP_DOUBLE           0
`define GRP_CORE             1
`define GRP_BUS_QUAL         2
`define GRP_BUS              3
`define GRP_PCI              4

// fanout of the replicated output pins
`define BUS_CLOCK_COUNT      5
`define PCI_CLOCK_COUNT      7

// pin synchroniser vector layout
`define SYNC_WIDTH           16
`define SY_LEGACY            0
`define SY_BUS_SEL_LO        1
`define SY_BUS_SEL_HI        2
`define SY_PCI_SEL_LO        3
`define SY_PCI_SEL_HI        4
`define SY_PRESCALER_BYPASS  5
`define SY_FEEDBACK_SEL      6
`define SY_REFERENCE_SEL     7
`define SY_LOOP_BYPASS_N     8
`define SY_STROBE_N          9
`define SY_COMMON_N          10
`define SY_FRZ_DATA          11
`define SY_FRZ_CLOCK         12
`define SY_TEST_REF          13
`define SY_CRYSTAL           14
`define SY_EXTERNAL_FEEDBACK_IN            15

`endif

// ---- rtl/ratio_divider.v ----
// one 50% duty divider stage stepped by the shared divider tick
`timescale 1ns/1ps
`default_nettype none
`include "pll_divider_map.vh"

module ratio_divider (
   // clock and clear
   input  wire                       clk,
   input  wire                       clear,
   // step and ratio
   input  wire                       tick,
   input  wire [`PERIOD_WIDTH-1:0]   period,
   // waveform
   output reg                        wave,
   output reg  [`PERIOD_WIDTH-1:0]   count
);

   wire [`PERIOD_WIDTH-1:0] lastCount = period - 6'h01;
   wire [`PERIOD_WIDTH-1:0] halfCount = {1'b0, period[`PERIOD_WIDTH-1:1]};
   reg  [`PERIOD_WIDTH-1:0] next_count;

   // a shrinking ratio wraps at once instead of running past the end
   always @* begin
      if (count >= lastCount)
         next_count = 6'h00;
      else
         next_count = count + 6'h01;
   end

   always @(posedge clk) begin
      if (clear) begin
         count <= 6'h00;
         wave  <= 1'b1;
      end else if (tick) begin
         count <= next_count;
         wave  <= (next_count < halfCount);
      end
   end

endmodule
`default_nettype wire

// ---- rtl/pll_output_divider_freeze.v ----
// digital side of a pll clock driver: output dividers, freeze and source select
// Notes on behaviour
// - strobe falling edge freezes outputs, each while its own wave is low
// - common hold applied on strobe falling edge
// - bus ratio select divides core qualifier 1-4
// - legacy bus qualifier follows bus clock rate
// - pci select: bus, bus/2, bus/3, core
// - non-legacy: double and qualifiers at vco/4
// - double clock vco/2 legacy, else vco/4
// - core qualifier vco/4 in both modes with prescaler bypassed
// - bus qualifier duty 66/33 and 75/25
// - non-legacy bus qualifier vco/4, no lag
// - double, core, bus, pci at 50% duty
// - feedback select high picks internal feedback
// - external feedback drives detector when selected
// - master reset clears flops, floats outputs
// - reference select low test clock, high crystal
// - internal divide-by-32 feedback ignores prescaler
// - multiplication equals 32 over divide ratio
// - prescaler select low inserts divide by two
// - per-output freeze bits shift in serially
// - loop bypass routes test clock through dividers
`timescale 1ns/1ps
`default_nettype none
`include "pll_divider_map.vh"

module pll_output_divider_freeze (
   // vco clock and synchronous reset
   input  wire                          clk,
   input  wire                          srst,
   // master reset and float, active low
   input  wire                          master_reset_float_n,
   // ratio straps
   input  wire                          legacy_cpu_mode,
   input  wire [1:0]                    bus_clock_ratio_sel,
   input  wire [1:0]                    pci_ratio_sel,
   input  wire                          prescaler_bypass_sel,
   // loop source selection
   input  wire                          feedback_source_sel,
   input  wire                          reference_source_sel,
   input  wire                          loop_bypass_n,
   input  wire                          test_reference_clock,
   input  wire                          crystal_clock,
   input  wire                          external_feedback_in,
   // freeze control
   input  wire                          freeze_strobe_n,
   input  wire                          common_freeze_n,
   input  wire                          freeze_data,
   input  wire                          freeze_clock,
   // phase detector inputs
   output reg                           detectorReference,
   output reg                           detectorFeedback,
   output reg                           loopBypassed,
   // clock outputs and their enables
   output reg                           double_core_clock,
   output reg                           double_core_clock_oe,
   output reg                           core_clock_qualifier,
   output reg                           core_clock_qualifier_oe,
   output reg                           bus_clock_qualifier,
   output reg                           bus_clock_qualifier_oe,
   output reg  [`BUS_CLOCK_COUNT-1:0]   busClock,
   output reg  [`BUS_CLOCK_COUNT-1:0]   busClockOe,
   output reg  [`PCI_CLOCK_COUNT-1:0]   pciClock,
   output reg  [`PCI_CLOCK_COUNT-1:0]   pciClockOe
);

   // pin synchronisers; first stage feeds only the second
   wire [`SYNC_WIDTH-1:0] pinRaw = {external_feedback_in, crystal_clock, test_reference_clock,
                                    freeze_clock, freeze_data, common_freeze_n, freeze_strobe_n,
                                    loop_bypass_n, reference_source_sel, feedback_source_sel,
                                    prescaler_bypass_sel, pci_ratio_sel, bus_clock_ratio_sel,
                                    legacy_cpu_mode};
   reg  [`SYNC_WIDTH-1:0] pinMeta;
   reg  [`SYNC_WIDTH-1:0] pinSync;
   reg  [`SYNC_WIDTH-1:0] pinPrev;
   reg                    masterMeta;
   reg                    masterSync;

   always @(posedge clk) begin
      if (srst) begin
         pinMeta    <= 16'h0000;
         pinSync    <= 16'h0000;
         masterMeta <= 1'b0;
         masterSync <= 1'b0;
      end else begin
         pinMeta    <= pinRaw;
         pinSync    <= pinMeta;
         masterMeta <= master_reset_float_n;
         masterSync <= masterMeta;
      end
   end

   // master reset acts as a second clear source for every flop after the pin synchronisers
   wire clearAll = srst | ~masterSync;

   // prev cleared low: an idle-high strobe cannot fake a fall after reset
   always @(posedge clk) begin
      if (clearAll)
         pinPrev <= 16'h0000;
      else
         pinPrev <= pinSync;
   end

   wire       legacy     = pinSync[`SY_LEGACY];
   wire [1:0] busSel     = {pinSync[`SY_BUS_SEL_HI], pinSync[`SY_BUS_SEL_LO]};
   wire [1:0] pciSel     = {pinSync[`SY_PCI_SEL_HI], pinSync[`SY_PCI_SEL_LO]};
   wire       strobeFall = pinPrev[`SY_STROBE_N] & ~pinSync[`SY_STROBE_N];
   wire       frzClkRise = ~pinPrev[`SY_FRZ_CLOCK] & pinSync[`SY_FRZ_CLOCK];
   wire       testRise   = ~pinPrev[`SY_TEST_REF] & pinSync[`SY_TEST_REF];

   // internal feedback divider runs straight off the vco, ahead of the prescaler
   reg [`FEEDBACK_DIV_WIDTH-1:0] feedbackCount;

   always @(posedge clk) begin
      if (clearAll)
         feedbackCount <= 5'h00;
      else
         feedbackCount <= feedbackCount + 5'h01;
   end

   // divide-by-32 feedback; output ratio n then multiplies by 32/n
   wire internalFeedback = feedbackCount[`FEEDBACK_DIV_WIDTH-1];

   always @(posedge clk) begin
      if (clearAll) begin
         detectorReference <= 1'b0;
         detectorFeedback  <= 1'b0;
         loopBypassed      <= 1'b0;
      end else begin
         detectorReference <= pinSync[`SY_REFERENCE_SEL] ? pinSync[`SY_CRYSTAL]
                                                         : pinSync[`SY_TEST_REF];
         detectorFeedback  <= pinSync[`SY_FEEDBACK_SEL] ? internalFeedback
                                                        : pinSync[`SY_EXTERNAL_FEEDBACK_IN];
         loopBypassed      <= ~pinSync[`SY_LOOP_BYPASS_N];
      end
   end

   // ratio straps only pass the pin synchronisers; change them only under reset
   // divider tick: test clock edges in bypass, else vco with optional halving
   reg  prescaleHalf;
   reg  dividerTick;
   wire next_tick = ~pinSync[`SY_LOOP_BYPASS_N] ? testRise
                  : (pinSync[`SY_PRESCALER_BYPASS] | prescaleHalf);

   always @(posedge clk) begin
      if (clearAll) begin
         prescaleHalf <= 1'b0;
         dividerTick  <= 1'b0;
      end else begin
         prescaleHalf <= ~prescaleHalf;
         dividerTick  <= next_tick;
      end
   end

   // ratios in ticks; every period is a multiple of the shorter ones so edges line up
   wire [`PERIOD_WIDTH-1:0] doublePeriod = legacy ? `DOUBLE_LEGACY_PERIOD : `CORE_PERIOD;
   wire [`PERIOD_WIDTH-1:0] busPeriod    = {2'b00, busSel, 2'b00} + `CORE_PERIOD;
   reg  [`PERIOD_WIDTH-1:0] pciPeriod;

   always @* begin
      case (pciSel)
         `PCI_SEL_BUS:      pciPeriod = busPeriod;
         `PCI_SEL_BUS_DIV2: pciPeriod = {busPeriod[`PERIOD_WIDTH-2:0], 1'b0};
         `PCI_SEL_BUS_DIV3: pciPeriod = {busPeriod[`PERIOD_WIDTH-2:0], 1'b0} + busPeriod;
         `PCI_SEL_CORE:     pciPeriod = `CORE_PERIOD;
         default:           pciPeriod = busPeriod;
      endcase
   end

   wire                     doubleWave;
   wire                     coreWave;
   wire                     busWave;
   wire                     pciWave;
   wire [`PERIOD_WIDTH-1:0] busCount;

   ratio_divider doubleDiv (
      .clk    (clk),
      .clear  (clearAll),
      .tick   (dividerTick),
      .period (doublePeriod),
      .wave   (doubleWave),
      .count  ()
   );

   ratio_divider coreDiv (
      .clk    (clk),
      .clear  (clearAll),
      .tick   (dividerTick),
      .period (`CORE_PERIOD),
      .wave   (coreWave),
      .count  ()
   );

   ratio_divider busDiv (
      .clk    (clk),
      .clear  (clearAll),
      .tick   (dividerTick),
      .period (busPeriod),
      .wave   (busWave),
      .count  (busCount)
   );

   ratio_divider pciDiv (
      .clk    (clk),
      .clear  (clearAll),
      .tick   (dividerTick),
      .period (pciPeriod),
      .wave   (pciWave),
      .count  ()
   );

   // legacy bus qualifier: low only in the last core period of each bus period
   reg  busQualWave;
   reg  busQualLag;
   wire legacyQual = (busSel == `BUS_SEL_DIV1) ? coreWave
                   : (busCount < busPeriod - `QUAL_LOW_TAIL);

   always @(posedge clk) begin
      if (clearAll) begin
         busQualWave <= 1'b1;
         busQualLag  <= 1'b1;
      end else begin
         busQualWave <= legacyQual;
         busQualLag  <= busQualWave;
      end
   end

   // legacy mode lags the qualifier to give the cpu hold margin; otherwise coincident
   wire busQualOut = legacy ? busQualLag : coreWave;

   // serial freeze bits are only applied when the strobe falls
   reg [`OUT_GROUPS-1:0] freezeShift;
   reg [`OUT_GROUPS-1:0] freezeTarget;
   reg                   commonHold;

   always @(posedge clk) begin
      if (clearAll) begin
         freezeShift  <= 5'h00;
         freezeTarget <= 5'h00;
         commonHold   <= 1'b0;
      end else begin
         if (frzClkRise)
            freezeShift <= {freezeShift[`OUT_GROUPS-2:0], pinSync[`SY_FRZ_DATA]};
         if (strobeFall) begin
            freezeTarget <= freezeShift;
            commonHold   <= ~pinSync[`SY_COMMON_N];
         end
      end
   end

   // bit order matches the serial freeze positions
   wire [`OUT_GROUPS-1:0] waves = {pciWave, busWave, busQualOut, coreWave, doubleWave};
   reg  [`OUT_GROUPS-1:0] frozen;
   reg  [`OUT_GROUPS-1:0] gated;

   // each group switches freeze state only while its own wave is low
   // frozen groups park low; enables stay up so loads see a steady level
   genvar g;
   generate
      for (g = 0; g < `OUT_GROUPS; g = g + 1) begin : freezeGate
         always @(posedge clk) begin
            if (clearAll) begin
               frozen[g] <= 1'b0;
               gated[g]  <= 1'b0;
            end else begin
               if (!waves[g])
                  frozen[g] <= freezeTarget[g] | commonHold;
               gated[g] <= waves[g] & ~frozen[g];
            end
         end
      end
   endgenerate

   // output flops; enables drop while master reset holds so pins float
   always @(posedge clk) begin
      if (clearAll) begin
         double_core_clock       <= 1'b0;
         double_core_clock_oe    <= 1'b0;
         core_clock_qualifier    <= 1'b0;
         core_clock_qualifier_oe <= 1'b0;
         bus_clock_qualifier     <= 1'b0;
         bus_clock_qualifier_oe  <= 1'b0;
         busClock                <= 5'h00;
         busClockOe              <= 5'h00;
         pciClock                <= 7'h00;
         pciClockOe              <= 7'h00;
      end else begin
         double_core_clock       <= gated[`GRP_DOUBLE];
         double_core_clock_oe    <= 1'b1;
         core_clock_qualifier    <= gated[`GRP_CORE];
         core_clock_qualifier_oe <= 1'b1;
         bus_clock_qualifier     <= gated[`GRP_BUS_QUAL];
         bus_clock_qualifier_oe  <= 1'b1;
         busClock                <= {`BUS_CLOCK_COUNT{gated[`GRP_BUS]}};
         busClockOe              <= 5'h1f;
         pciClock                <= {`PCI_CLOCK_COUNT{gated[`GRP_PCI]}};
         pciClockOe              <= 7'h7f;
      end
   end

endmodule
`default_nettype wire

// ---- sim/pll_divider_checker_assertions.sv ----
// checker for the pll output divider and freeze block
`timescale 1ns/1ps
`default_nettype none
module pll_divider_checker (
   // clock, resets and straps
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       master_reset_float_n,
   input wire logic       legacy_cpu_mode,
   input wire logic [1:0] bus_clock_ratio_sel,
   input wire logic       feedback_source_sel,
   input wire logic       loop_bypass_n,
   input wire logic       external_feedback_in,
   input wire logic       freeze_strobe_n,
   input wire logic       reference_source_sel,
   input wire logic       test_reference_clock,
   input wire logic       crystal_clock,
   // watched outputs
   input wire logic       detectorReference,
   input wire logic       detectorFeedback,
   input wire logic       loopBypassed,
   input wire logic       double_core_clock_oe,
   input wire logic       core_clock_qualifier,
   input wire logic       bus_clock_qualifier,
   input wire logic [4:0] busClock,
   input wire logic [6:0] pciClock,
   input wire logic [6:0] pciClockOe
);
   // settled once synchronisers refill; a freeze may hold any or all groups low, so it ends the quiet span
   logic [3:0] sinceRst;
   logic       frzSeen;
   wire        settled = sinceRst == 4'hf;
   wire        quiet = settled && !frzSeen;
   wire        live = double_core_clock_oe | (|pciClockOe) | core_clock_qualifier | (|busClock) | (|pciClock);
   always @(posedge clk) begin
      if (srst || !master_reset_float_n) begin
         sinceRst <= 4'h0;
      end else if (sinceRst != 4'hf) begin
         sinceRst <= sinceRst + 4'h1;
      end
      frzSeen <= !srst && (frzSeen || !freeze_strobe_n);
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   reset_clears_a: assert property ($fell(srst) |-> !live)
      else $error("outputs live right after reset");
   master_float_a: assert property (!master_reset_float_n [*4] |=> !live)
      else $error("outputs driven in master reset");
   fanout_equal_a: assert property (busClock == {5{busClock[0]}} && pciClock == {7{pciClock[0]}})
      else $error("replicated clocks differ");
   no_lag_a: assert property (quiet && !legacy_cpu_mode |-> bus_clock_qualifier == core_clock_qualifier)
      else $error("bus qualifier not coincident");
   legacy_lag_a: assert property (quiet && legacy_cpu_mode && bus_clock_ratio_sel == 2'h0
      |-> bus_clock_qualifier == $past(core_clock_qualifier, 2)) else $error("bus qualifier lag wrong");
   core_pulse_a: assert property ($rose(core_clock_qualifier) && settled |=> core_clock_qualifier)
      else $error("runt core qualifier pulse");
   pci_gap_a: assert property ($fell(pciClock[0]) |=> !pciClock[0])
      else $error("runt pci low phase");
   ext_feedback_a: assert property ((settled && !feedback_source_sel) [*5]
      |-> detectorFeedback == $past(external_feedback_in, 3)) else $error("external feedback not routed");
   bypass_route_a: assert property ((settled && !loop_bypass_n) [*5] |-> loopBypassed)
      else $error("loop bypass not shown");
   ref_route_a: assert property (settled |-> detectorReference == (reference_source_sel ? $past(crystal_clock, 3)
      : $past(test_reference_clock, 3))) else $error("reference source not routed");
   cover property (quiet && legacy_cpu_mode && bus_clock_ratio_sel == 2'h3);
   cover property ($fell(freeze_strobe_n));
   cover property (!master_reset_float_n [*4] ##1 !live);
endmodule
bind pll_output_divider_freeze pll_divider_checker chk (.clk, .srst, .master_reset_float_n, .legacy_cpu_mode,
   .bus_clock_ratio_sel, .feedback_source_sel, .loop_bypass_n, .external_feedback_in, .freeze_strobe_n,
   .reference_source_sel, .test_reference_clock, .crystal_clock, .detectorReference,
   .detectorFeedback, .loopBypassed, .double_core_clock_oe, .core_clock_qualifier, .bus_clock_qualifier,
   .busClock, .pciClock, .pciClockOe);
`default_nettype wire

// ---- sim/clock_load_model.sv ----
// clock loads: time each rise of five output groups
`timescale 1ns/1ps
`default_nettype none
module clock_load_model (
   // vco clock and observed waves
   input  wire logic       clk,
   input  wire logic [4:0] wave,
   // last period, high time and rise count
   output int              per [0:4],
   output int              hi  [0:4],
   output int              nr  [0:4]
);
   int         cnt [0:4];
   int         hc  [0:4];
   logic [4:0] prev = 5'h00;
   always @(posedge clk) begin
      for (int g = 0; g < 5; g++) begin
         if (wave[g] && !prev[g]) begin
            per[g] <= cnt[g];
            hi[g] <= hc[g];
            nr[g] <= nr[g] + 1;
            cnt[g] <= 1;
            hc[g] <= 1;
         end else begin
            cnt[g] <= cnt[g] + 1;
            hc[g] <= hc[g] + int'(wave[g]);
         end
      end
      prev <= wave;
   end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// bench for the pll output divider and freeze block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic       clk = 1'b0, srst = 1'b1, master_reset_float_n = 1'b1, legacy_cpu_mode = 1'b1;
   logic       prescaler_bypass_sel = 1'b1, feedback_source_sel = 1'b1, reference_source_sel = 1'b1;
   logic       loop_bypass_n = 1'b1, test_reference_clock = 1'b0, crystal_clock = 1'b0;
   logic       external_feedback_in = 1'b0, freeze_strobe_n = 1'b1, common_freeze_n = 1'b1;
   logic       freeze_data = 1'b0, freeze_clock = 1'b0;
   logic [1:0] bus_clock_ratio_sel = 2'h0, pci_ratio_sel = 2'h0;
   logic       detectorReference, detectorFeedback, loopBypassed, double_core_clock, double_core_clock_oe;
   logic       core_clock_qualifier, core_clock_qualifier_oe, bus_clock_qualifier, bus_clock_qualifier_oe;
   logic [4:0] busClock, busClockOe;
   logic [6:0] pciClock, pciClockOe;
   int         per [0:4], hi [0:4], nr [0:4];
   int         nErrors = 0, checked = 0, cycles = 0, mult = 1;
   pll_output_divider_freeze DUT (.clk, .srst, .master_reset_float_n, .legacy_cpu_mode, .bus_clock_ratio_sel,
      .pci_ratio_sel, .prescaler_bypass_sel, .feedback_source_sel, .reference_source_sel, .loop_bypass_n,
      .test_reference_clock, .crystal_clock, .external_feedback_in, .freeze_strobe_n, .common_freeze_n,
      .freeze_data, .freeze_clock, .detectorReference, .detectorFeedback, .loopBypassed, .double_core_clock,
      .double_core_clock_oe, .core_clock_qualifier, .core_clock_qualifier_oe, .bus_clock_qualifier,
      .bus_clock_qualifier_oe, .busClock, .busClockOe, .pciClock, .pciClockOe);
   clock_load_model loads (.clk, .wave({pciClock[0], busClock[0], bus_clock_qualifier, core_clock_qualifier,
      double_core_clock}), .per, .hi, .nr);
   initial begin
      forever #2 clk = ~clk;
   end
   // test clock at a quarter of the vco rate doubles as the bypass tick source
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles % 2 == 1) test_reference_clock <= ~test_reference_clock;
      external_feedback_in <= 1'($urandom);
      crystal_clock <= 1'($urandom);
      if (cycles == 40000) begin
         nErrors++;
         give_verdict();
      end
   end
   task cmp_int(input int got, input int exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH at %0t: timing %0d, expected %0d", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         nErrors++;
         $display("MISMATCH at %0t: level %b, expected %b", $time, got, exp);
      end
   endtask
   // expected period and high time in vco cycles for one output group
   task automatic expect_wave(input int g, output int p, output int h);
      int b;
      b = 4 * (bus_clock_ratio_sel + 1);
      case (g)
         0: p = legacy_cpu_mode ? 2 : 4;
         1: p = 4;
         2: p = legacy_cpu_mode ? b : 4;
         3: p = b;
         default: p = (pci_ratio_sel == 2'h3) ? 4 : b * (pci_ratio_sel + 1);
      endcase
      h = (g == 2 && legacy_cpu_mode && bus_clock_ratio_sel != 2'h0) ? p - 4 : p / 2;
      p = p * mult;
      h = h * mult;
   endtask
   task automatic run_config(input int i);
      int   start [0:4];
      int   k, g, p, h;
      logic busy, fb;
      @(posedge clk);
      srst <= 1'b1;
      legacy_cpu_mode <= (i < 16 || i >= 32);
      prescaler_bypass_sel <= (i < 32 || i == 48);
      loop_bypass_n <= (i != 48);
      bus_clock_ratio_sel <= 2'(i % 4);
      pci_ratio_sel <= 2'(i / 4 % 4);
      feedback_source_sel <= 1'($urandom);
      reference_source_sel <= 1'($urandom);
      mult = (i == 48) ? 4 : ((i >= 32) ? 2 : 1);
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      repeat (8) @(posedge clk);
      start = nr;
      for (k = 0; k < 1000; k++) begin
         @(posedge clk);
         busy = 1'b0;
         for (g = 0; g < 5; g++) if (nr[g] < start[g] + 3) busy = 1'b1;
         if (!busy) break;
      end
      cmp_bit(busy, 1'b0);
      // internal feedback is vco/32 whatever the prescaler: 16 vco cycles per level
      fb = detectorFeedback;
      for (k = 0; k < 40 && detectorFeedback == fb; k++) @(posedge clk);
      fb = detectorFeedback;
      for (k = 0; k < 40 && detectorFeedback == fb; k++) @(posedge clk);
      if (feedback_source_sel) cmp_int(k, 16);
      for (g = 0; g < 5; g++) begin
         expect_wave(g, p, h);
         cmp_int(per[g], p);
         cmp_int(hi[g], h);
      end
      cmp_bit(&{double_core_clock_oe, bus_clock_qualifier_oe, busClockOe, pciClockOe}, 1'b1);
      $display("config %0d done", i);
   endtask
   // serial bits go first, the strobe fall then applies them with the common hold
   task automatic freeze_case(input logic [4:0] bits, input logic com);
      int snap [0:4];
      int k, g;
      for (k = 4; k >= 0; k--) begin
         freeze_data <= bits[k];
         repeat (4) @(posedge clk);
         freeze_clock <= 1'b1;
         repeat (4) @(posedge clk);
         freeze_clock <= 1'b0;
      end
      common_freeze_n <= com;
      repeat (4) @(posedge clk);
      freeze_strobe_n <= 1'b0;
      repeat (4) @(posedge clk);
      freeze_strobe_n <= 1'b1;
      repeat (30) @(posedge clk);
      snap = nr;
      repeat (40) @(posedge clk);
      for (g = 0; g < 5; g++) cmp_bit(nr[g] != snap[g], !(bits[g] || !com));
      $display("freeze %b hold %b done", bits, com);
   endtask
   task give_verdict();
      $display("comparisons %0d, mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      void'($urandom(51));
      for (int i = 0; i < 49; i++) run_config(i);
      master_reset_float_n <= 1'b0;
      repeat (6) @(posedge clk);
      cmp_bit(|{double_core_clock_oe, core_clock_qualifier_oe, busClockOe, pciClockOe, busClock}, 1'b0);
      master_reset_float_n <= 1'b1;
      repeat (10) @(posedge clk);
      cmp_bit(core_clock_qualifier_oe, 1'b1);
      $display("master reset test done");
      run_config(0);
      freeze_case(5'h00, 1'b0);
      freeze_case(5'h00, 1'b1);
      repeat (3) freeze_case(5'($urandom), 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
